// ---- cev_map.svh ----
// Register offsets, field positions and reset values of the comparator event block
`ifndef CEV_MAP_SVH
`define CEV_MAP_SVH
`define CEV_ADDR_W 4
`define CEV_OFF_CTRL0 4'h0
`define CEV_OFF_CTRL1 4'h1
`define CEV_OFF_CTRL2 4'h2
`define CEV_OFF_CTRL3 4'h3
`define CEV_OFF_FLAGS 4'h4
`define CEV_OFF_DIS_LO 4'h5
`define CEV_OFF_DIS_HI 4'h6
`define CEV_OFF_IRQ_STAT 4'h7
`define CEV_OFF_IRQ_CLR 4'h8
`define CEV_OFF_IRQ_EN 4'h9
`define CEV_FLAG_LSB 4
`define CEV_B3_BIT 3
`define CEV_CTRL_RST 8'h00
`define CEV_STAT_RST 8'h00
`define CEV_DIS_RST 8'h00
`define CEV_DIS_LO_MASK 8'h6D
`define CEV_DIS_HI_MASK 8'h26
`endif

// ---- cev_pkg.sv ----
// Types shared by the comparator event block
package cev_pkg;
  typedef enum logic [1:0] {
    CEV_IS_ANY = 2'h0,
    CEV_IS_RSVD = 2'h1,
    CEV_IS_FALL = 2'h2,
    CEV_IS_RISE = 2'h3
  } cev_sense_t;

  typedef struct packed {
    logic on;
    logic irq_allow;
    cev_sense_t sense;
    logic b3;
    logic [2:0] neg_sel;
  } cev_ctrl_t;

  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
  } cev_pins_t;
endpackage

// ---- cev_top.sv ----
// Control, flag and input-disable logic for four analog comparators
//
// What this block does
// - Control bit 7 turns its comparator on when one, off when zero.
// - Control bit 6 lets that comparator's interrupt request through.
// - Bits 5:4 pick event: 00 toggle, 10 falling, 11 rising, 01 none.
// - Bits 2:0 steer the negative input; code 111 is reserved.
// - Bit 3 of controls 2 and 3 is unused and reads zero.
// - Chosen output event sets flag; flags sit at status bits 7:4.
// - Taking the vector clears the flag, only when interrupt allowed.
// - Writing one to a flag clears it; zero leaves it.
// - Each flag also goes out as a conversion trigger.
// - Status bits 3:0 show live comparator outputs, read only.
// - A one in a disable bit turns that pin's input buffer off.
// - While disabled, the pin's read value is always zero.
// - Second disable register holds bits 5, 2, 1, same behaviour.
// - Control 0 bit 3 picks comparator clock: one PLL, zero I/O.
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`include "cev_map.svh"

module cev_top #(
  parameter int NCMP = 4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [`CEV_ADDR_W-1:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic [NCMP-1:0] cmp_raw,
  input wire logic io_clk_tick,
  input wire logic pll_clk_tick,
  input wire logic [NCMP-1:0] vec_ack,
  input wire cev_pkg::cev_pins_t pin_raw,
  output cev_pkg::cev_pins_t pin_read,
  output cev_pkg::cev_pins_t pin_buf_off,
  output logic [NCMP-1:0] cmp_on,
  output logic [3*NCMP-1:0] neg_sel,
  output logic cmp_clock_choice,
  output logic capture_en,
  output logic [NCMP-1:0] cmp_irq_req,
  output logic [NCMP-1:0] conv_trigger,
  output logic irq
);

  cev_pkg::cev_ctrl_t ctrl_reg [NCMP];
  logic [NCMP-1:0] lvl_s1_reg;
  logic [NCMP-1:0] lvl_s2_reg;
  logic [NCMP-1:0] prev_reg;
  logic [NCMP-1:0] flag_reg;
  logic [NCMP-1:0] flag_next;
  logic [NCMP-1:0] evt;
  logic [NCMP-1:0] on_vec;
  logic [NCMP-1:0] ie_vec;
  logic [NCMP-1:0] ist_reg;
  logic [NCMP-1:0] ist_next;
  logic [NCMP-1:0] ien_reg;
  cev_pkg::cev_pins_t pin_s1_reg;
  cev_pkg::cev_pins_t pin_s2_reg;
  cev_pkg::cev_pins_t dis_next;
  logic cmp_tick;
  logic wr_flags;
  logic [7:0] rd_mux;

  // Event decode from sense field and the two samples
  function automatic logic sense_hit(cev_pkg::cev_sense_t s, logic cur, logic prv);
    logic hit;
    hit = 1'b0;
    unique case (s)
      cev_pkg::CEV_IS_ANY: hit = cur ^ prv;
      cev_pkg::CEV_IS_FALL: hit = prv & ~cur;
      cev_pkg::CEV_IS_RISE: hit = cur & ~prv;
      cev_pkg::CEV_IS_RSVD: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Comparator clock chosen by control 0 bit 3
  assign cmp_tick = ctrl_reg[0].b3 ? pll_clk_tick : io_clk_tick;
  assign wr_flags = bus_wr && (bus_addr == `CEV_OFF_FLAGS);

  // Comparator outputs arrive asynchronously, two flops before use
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lvl_s1_reg <= '0;
      lvl_s2_reg <= '0;
    end else begin
      lvl_s1_reg <= cmp_raw;
      lvl_s2_reg <= lvl_s1_reg;
    end
  end

  generate
    for (genvar i = 0; i < NCMP; i++) begin : g_cmp
      // Control register; bit 3 of upper comparators is not stored
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          ctrl_reg[i] <= `CEV_CTRL_RST;
        end else if (bus_wr && (bus_addr == `CEV_OFF_CTRL0 + `CEV_ADDR_W'(i))) begin
          ctrl_reg[i] <= bus_wdata;
          if (i >= 2) begin
            ctrl_reg[i].b3 <= 1'b0;
          end
        end
      end

      // Previous sample taken only on comparator ticks
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          prev_reg[i] <= 1'b0;
        end else if (cmp_tick) begin
          prev_reg[i] <= lvl_s2_reg[i];
        end
      end

      assign on_vec[i] = ctrl_reg[i].on;
      assign ie_vec[i] = ctrl_reg[i].irq_allow;
      // Disabled comparator raises no event
      assign evt[i] = cmp_tick && ctrl_reg[i].on
                      && sense_hit(ctrl_reg[i].sense, lvl_s2_reg[i], prev_reg[i]);
      // Set beats either clear so no event is lost
      assign flag_next[i] = evt[i] ? 1'b1 :
                            ((vec_ack[i] && ctrl_reg[i].irq_allow) ? 1'b0 :
                            ((wr_flags && bus_wdata[`CEV_FLAG_LSB+i]) ? 1'b0 :
                            flag_reg[i]));
      assign neg_sel[3*i +: 3] = ctrl_reg[i].neg_sel;
    end
  endgenerate

  // Event flags and what they drive
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= '0;
      cmp_irq_req <= '0;
      conv_trigger <= '0;
    end else begin
      flag_reg <= flag_next;
      cmp_irq_req <= flag_next & ie_vec;
      conv_trigger <= flag_next;
    end
  end

  // Control bits brought out from their registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmp_on <= '0;
      cmp_clock_choice <= 1'b0;
      capture_en <= 1'b0;
    end else begin
      cmp_on <= on_vec;
      cmp_clock_choice <= ctrl_reg[0].b3;
      capture_en <= ctrl_reg[1].b3;
    end
  end

  // Input-disable registers; only implemented bits hold a value
  always_comb begin
    dis_next = pin_buf_off;
    if (bus_wr && (bus_addr == `CEV_OFF_DIS_LO)) begin
      dis_next.lo = bus_wdata & `CEV_DIS_LO_MASK;
    end
    if (bus_wr && (bus_addr == `CEV_OFF_DIS_HI)) begin
      dis_next.hi = bus_wdata & `CEV_DIS_HI_MASK;
    end
  end

  // Pin reads synchronised, then forced low where the buffer is off
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_read <= '0;
      pin_buf_off <= {`CEV_DIS_RST, `CEV_DIS_RST};
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_buf_off <= dis_next;
      pin_read <= pin_s2_reg & ~dis_next;
    end
  end

  // Sticky interrupt status, write-one clear, set wins
  assign ist_next = evt | (ist_reg & ~((bus_wr && (bus_addr == `CEV_OFF_IRQ_CLR))
                                       ? bus_wdata[NCMP-1:0] : {NCMP{1'b0}}));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ist_reg <= '0;
      ien_reg <= '0;
      irq <= 1'b0;
    end else begin
      ist_reg <= ist_next;
      if (bus_wr && (bus_addr == `CEV_OFF_IRQ_EN)) begin
        ien_reg <= bus_wdata[NCMP-1:0];
        irq <= |(ist_next & bus_wdata[NCMP-1:0]);
      end else begin
        irq <= |(ist_next & ien_reg);
      end
    end
  end

  // Read decode; unmapped and write-only addresses read zero
  always_comb begin
    rd_mux = 8'h00;
    unique case (bus_addr)
      `CEV_OFF_CTRL0: rd_mux = ctrl_reg[0];
      `CEV_OFF_CTRL1: rd_mux = ctrl_reg[1];
      `CEV_OFF_CTRL2: rd_mux = ctrl_reg[2];
      `CEV_OFF_CTRL3: rd_mux = ctrl_reg[3];
      `CEV_OFF_FLAGS: rd_mux = {flag_reg, lvl_s2_reg};
      `CEV_OFF_DIS_LO: rd_mux = pin_buf_off.lo;
      `CEV_OFF_DIS_HI: rd_mux = pin_buf_off.hi;
      `CEV_OFF_IRQ_STAT: rd_mux = {4'h0, ist_reg};
      `CEV_OFF_IRQ_EN: rd_mux = {4'h0, ien_reg};
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= 8'h00;
    end else begin
      bus_rdata <= bus_rd ? rd_mux : 8'h00;
    end
  end

  // Checks on flag, request and read behaviour
  property p_flag_set;
    @(posedge clk_sys) disable iff (!rst_n)
      (cmp_tick && ctrl_reg[0].on && ctrl_reg[0].sense == cev_pkg::CEV_IS_RISE
       && lvl_s2_reg[0] && !prev_reg[0]) |=> flag_reg[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("rising event did not set flag");

  property p_off_no_set;
    @(posedge clk_sys) disable iff (!rst_n)
      (!ctrl_reg[1].on && !flag_reg[1] && !(vec_ack[1] || wr_flags)) |=> !flag_reg[1];
  endproperty
  a_off_no_set: assert property (p_off_no_set) else $error("disabled comparator set flag");

  property p_set_wins;
    @(posedge clk_sys) disable iff (!rst_n)
      (evt[2] && wr_flags && bus_wdata[`CEV_FLAG_LSB+2]) |=> flag_reg[2];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a same-cycle event");

  property p_sw_clear;
    @(posedge clk_sys) disable iff (!rst_n)
      (wr_flags && bus_wdata[`CEV_FLAG_LSB+3] && !evt[3]) |=> !flag_reg[3];
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("write one did not clear flag");

  property p_ack_clear;
    @(posedge clk_sys) disable iff (!rst_n)
      (vec_ack[1] && ie_vec[1] && !evt[1]) |=> !flag_reg[1] && !cmp_irq_req[1];
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("vector ack did not clear flag");

  property p_ack_keep;
    @(posedge clk_sys) disable iff (!rst_n)
      (vec_ack[1] && !ie_vec[1] && flag_reg[1] && !wr_flags) |=> flag_reg[1];
  endproperty
  a_ack_keep: assert property (p_ack_keep) else $error("ack cleared flag without permit");

  property p_req;
    @(posedge clk_sys) disable iff (!rst_n)
      ##1 (cmp_irq_req == (flag_reg & $past(ie_vec)));
  endproperty
  a_req: assert property (p_req) else $error("request does not follow flag and permit");

  property p_rsvd3;
    @(posedge clk_sys) disable iff (!rst_n)
      (bus_rd && bus_addr == `CEV_OFF_CTRL2) |=> !bus_rdata[`CEV_B3_BIT];
  endproperty
  a_rsvd3: assert property (p_rsvd3) else $error("unused control bit read as one");

  property p_level;
    @(posedge clk_sys) disable iff (!rst_n)
      (bus_rd && bus_addr == `CEV_OFF_FLAGS) |=> bus_rdata[3:0] == $past(lvl_s2_reg);
  endproperty
  a_level: assert property (p_level) else $error("status low bits not live outputs");

  property p_pin_mask;
    @(posedge clk_sys) disable iff (!rst_n)
      ((pin_read.lo & pin_buf_off.lo) == 8'h00) && ((pin_read.hi & pin_buf_off.hi) == 8'h00);
  endproperty
  a_pin_mask: assert property (p_pin_mask) else $error("disabled pin read as one");

  // Sense codes, edge history, triggers and the summed interrupt line
  property p_toggle;
    @(posedge clk_sys) disable iff (!rst_n)
      (cmp_tick && ctrl_reg[1].on && ctrl_reg[1].sense == cev_pkg::CEV_IS_ANY
       && (lvl_s2_reg[1] != prev_reg[1])) |=> flag_reg[1];
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle event did not set flag");

  property p_fall;
    @(posedge clk_sys) disable iff (!rst_n)
      (cmp_tick && ctrl_reg[3].on && ctrl_reg[3].sense == cev_pkg::CEV_IS_FALL
       && !lvl_s2_reg[3] && prev_reg[3]) |=> flag_reg[3];
  endproperty
  a_fall: assert property (p_fall) else $error("falling event did not set flag");

  property p_rsvd_sense;
    @(posedge clk_sys) disable iff (!rst_n)
      (ctrl_reg[2].sense == cev_pkg::CEV_IS_RSVD) |-> !evt[2];
  endproperty
  a_rsvd_sense: assert property (p_rsvd_sense) else $error("reserved sense set event");

  property p_prev;
    @(posedge clk_sys) disable iff (!rst_n)
      cmp_tick |=> (prev_reg == $past(lvl_s2_reg));
  endproperty
  a_prev: assert property (p_prev) else $error("edge history missed a tick");

  property p_trig;
    @(posedge clk_sys) disable iff (!rst_n)
      conv_trigger == flag_reg;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger differs from flag");

  property p_irq_sum;
    @(posedge clk_sys) disable iff (!rst_n)
      irq == |(ist_reg & ien_reg);
  endproperty
  a_irq_sum: assert property (p_irq_sum) else $error("irq not status and enable");

  property p_on_out;
    @(posedge clk_sys) disable iff (!rst_n)
      ##1 (cmp_on == $past(on_vec));
  endproperty
  a_on_out: assert property (p_on_out) else $error("enable output not its bit");

  c_rise: cover property (@(posedge clk_sys) disable iff (!rst_n) evt[0] ##1 flag_reg[0]);
  c_ack: cover property (@(posedge clk_sys) disable iff (!rst_n)
    flag_reg[1] && vec_ack[1] && ie_vec[1]);
  c_irq: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(irq));
  c_trig: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(conv_trigger[3]));
  c_set_wins: cover property (@(posedge clk_sys) disable iff (!rst_n)
    evt[2] && wr_flags && bus_wdata[`CEV_FLAG_LSB+2]);

endmodule // cev_top

// ---- cev_cpu_model.sv ----
// Interrupt-side model: takes each comparator vector once as its request rises
`timescale 1ns/1ns
module cev_cpu_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] cmp_irq_req,
  input wire logic spur,
  output logic [3:0] vec_ack
);
  logic [3:0] req_reg;
  // One-cycle vector pulse per new request; spur takes all vectors unasked
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      req_reg <= 4'h0;
      vec_ack <= 4'h0;
    end else begin
      req_reg <= cmp_irq_req;
      vec_ack <= (cmp_irq_req & ~req_reg) | {4{spur}};
    end
  end
endmodule // cev_cpu_model

// ---- comparator_event_control_test.sv ----
// Self-checking bench for the comparator event block
`timescale 1ns/1ns
`include "cev_map.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] t=%0t got %0h exp %0h", $time, (g), (e)); end end
module comparator_event_control_test;
  typedef struct packed {logic [3:0] a; logic [7:0] wd; logic [7:0] rd;} cev_reg_row_t;
  typedef struct packed {logic [7:0] ctrl; logic rise; logic hit;} cev_ev_row_t;
  logic clk_sys, rst_n, bus_wr, bus_rd, io_clk_tick, pll_clk_tick, spur, cmp_clock_choice;
  logic capture_en, irq;
  logic [`CEV_ADDR_W-1:0] bus_addr;
  logic [3:0] cmp_raw, vec_ack, cmp_on, cmp_irq_req, conv_trigger;
  logic [7:0] bus_wdata, bus_rdata, d;
  logic [11:0] neg_sel;
  cev_pkg::cev_pins_t pin_raw, pin_read, pin_buf_off;
  int error_cnt, n_tests, cycles, k, i;
  cev_reg_row_t regs [9] = '{'{`CEV_OFF_CTRL0, 8'hFF, 8'hFF}, '{`CEV_OFF_CTRL1, 8'hFF, 8'hFF},
    '{`CEV_OFF_CTRL2, 8'hFF, 8'hF7}, '{`CEV_OFF_CTRL3, 8'hFF, 8'hF7},
    '{`CEV_OFF_DIS_LO, 8'hFF, 8'h6D}, '{`CEV_OFF_DIS_HI, 8'hFF, 8'h26},
    '{`CEV_OFF_IRQ_EN, 8'h0F, 8'h0F}, '{4'hA, 8'hFF, 8'h00}, '{`CEV_OFF_IRQ_CLR, 8'h0F, 8'h00}};
  // Toggle, falling, rising, reserved sense, then comparator switched off
  cev_ev_row_t evs [9] = '{'{8'h80, 1'b1, 1'b1}, '{8'h80, 1'b0, 1'b1}, '{8'hA0, 1'b1, 1'b0},
    '{8'hA0, 1'b0, 1'b1}, '{8'hB0, 1'b1, 1'b1}, '{8'hB0, 1'b0, 1'b0}, '{8'h90, 1'b1, 1'b0},
    '{8'h90, 1'b0, 1'b0}, '{8'h30, 1'b1, 1'b0}};

  cev_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .cmp_raw(cmp_raw),
    .io_clk_tick(io_clk_tick), .pll_clk_tick(pll_clk_tick), .vec_ack(vec_ack),
    .pin_raw(pin_raw), .pin_read(pin_read), .pin_buf_off(pin_buf_off), .cmp_on(cmp_on),
    .neg_sel(neg_sel), .cmp_clock_choice(cmp_clock_choice), .capture_en(capture_en),
    .cmp_irq_req(cmp_irq_req), .conv_trigger(conv_trigger), .irq(irq));
  cev_cpu_model i_cpu (.clk_sys(clk_sys), .rst_n(rst_n), .cmp_irq_req(cmp_irq_req),
    .spur(spur), .vec_ack(vec_ack));

  // 125 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Both comparator clocks tick on alternate cycles, so either selection works
  always @(posedge clk_sys) begin
    io_clk_tick <= ~io_clk_tick;
    pll_clk_tick <= ~pll_clk_tick;
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      results();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= v;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask
  // Read data is only valid in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask
  task automatic results();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    {rst_n, bus_wr, bus_rd, io_clk_tick, spur, cmp_raw, bus_addr, bus_wdata} = '0;
    pll_clk_tick = 1'b1;
    pin_raw = 16'hFFFF;
    error_cnt = 0;
    n_tests = 0;
    cycles = 0;
    cyc(5);
    #1 `CHK({irq, cmp_irq_req, conv_trigger, cmp_on, bus_rdata}, 21'h0)
    // Release on the sixth edge, by the same rule as every other input
    @(posedge clk_sys) rst_n <= 1'b1;
    for (k = 0; k < 10; k++) begin
      rd(k[3:0]);
      `CHK(d, 8'h00)
    end
    // Register access table
    for (k = 0; k < 9; k++) begin
      wr(regs[k].a, regs[k].wd);
      rd(regs[k].a);
      `CHK(d, regs[k].rd)
    end
    `CHK({cmp_on, cmp_clock_choice, capture_en, neg_sel}, {4'hF, 2'b11, 12'hFFF})
    `CHK(pin_buf_off, {8'h6D, 8'h26})
    `CHK(pin_read, {8'h92, 8'hD9})
    // Edge sensitivity table, spread over the four comparators
    for (k = 0; k < 9; k++) begin
      i = k % 4;
      @(posedge clk_sys) cmp_raw[i] <= !evs[k].rise;
      cyc(6);
      wr(i[3:0], evs[k].ctrl);
      wr(`CEV_OFF_FLAGS, 8'hF0);
      @(posedge clk_sys) cmp_raw[i] <= evs[k].rise;
      cyc(8);
      rd(`CEV_OFF_FLAGS);
      `CHK(d, {4'(evs[k].hit) << i, cmp_raw})
      `CHK(conv_trigger[i], evs[k].hit)
    end
    // Event without permit: no request, stray vector must not clear
    wr(`CEV_OFF_CTRL1, 8'h80);
    wr(`CEV_OFF_IRQ_CLR, 8'h0F);
    wr(`CEV_OFF_FLAGS, 8'hF0);
    wr(`CEV_OFF_IRQ_EN, 8'h02);
    @(posedge clk_sys) cmp_raw[1] <= ~cmp_raw[1];
    cyc(8);
    `CHK({cmp_irq_req[1], irq, conv_trigger[1]}, 3'b011)
    @(posedge clk_sys) spur <= 1'b1;
    @(posedge clk_sys) spur <= 1'b0;
    cyc(3);
    rd(`CEV_OFF_FLAGS);
    `CHK(d[5], 1'b1)
    // Interrupt mask, unmask and clear
    wr(`CEV_OFF_IRQ_EN, 8'h00);
    cyc(2);
    `CHK(irq, 1'b0)
    wr(`CEV_OFF_IRQ_EN, 8'h02);
    cyc(2);
    `CHK(irq, 1'b1)
    wr(`CEV_OFF_IRQ_CLR, 8'h02);
    cyc(2);
    `CHK(irq, 1'b0)
    rd(`CEV_OFF_IRQ_STAT);
    `CHK(d, 8'h00)
    // Writing zero keeps the flag; permit raises request, vector clears it
    wr(`CEV_OFF_FLAGS, 8'h00);
    rd(`CEV_OFF_FLAGS);
    `CHK(d[5], 1'b1)
    wr(`CEV_OFF_CTRL1, 8'hC0);
    cyc(6);
    rd(`CEV_OFF_FLAGS);
    `CHK({d[5], cmp_irq_req[1]}, 2'b00)
    wr(`CEV_OFF_CTRL1, 8'h80);
    @(posedge clk_sys) cmp_raw[1] <= ~cmp_raw[1];
    cyc(8);
    wr(`CEV_OFF_FLAGS, 8'h20);
    rd(`CEV_OFF_FLAGS);
    `CHK(d[5], 1'b0)
    // Event and clearing write on one edge: the event must win
    wr(`CEV_OFF_CTRL2, 8'h80);
    @(posedge clk_sys);
    // Comparator clock is the I/O tick here; an untick edge means the third one ticks
    while (io_clk_tick) @(posedge clk_sys);
    cmp_raw[2] <= ~cmp_raw[2];
    cyc(2);
    bus_wr <= 1'b1;
    bus_addr <= `CEV_OFF_FLAGS;
    bus_wdata <= 8'h40;
    @(posedge clk_sys) bus_wr <= 1'b0;
    rd(`CEV_OFF_FLAGS);
    `CHK({d[6], conv_trigger[2]}, 2'b11)
    results();
  end
endmodule // comparator_event_control_test
